// ===== design/pll_cfg_pkg.sv
package pll_cfg_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [ADDR_W-1:0] ADDR_PLL_MAIN   = 10'h010;
	localparam logic [ADDR_W-1:0] ADDR_ABL_CTRL   = 10'h017;
	localparam logic [ADDR_W-1:0] ADDR_VCO_CAL    = 10'h018;
	localparam logic [ADDR_W-1:0] ADDR_VDIV_SEL   = 10'h1E0;
	localparam logic [ADDR_W-1:0] ADDR_DIST_SRC   = 10'h1E1;
	localparam logic [ADDR_W-1:0] ADDR_UPDATE     = 10'h232;
	localparam logic [ADDR_W-1:0] ADDR_CP_CURRENT = 10'h0F0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 10'h0F1;

	////////////////////////////////////////////////////////////////////////////////
	// Field values and reset values.
	localparam logic [1:0] PWR_RUN      = 2'h0;
	localparam logic [1:0] PWR_DOWN     = 2'h1;
	localparam logic [2:0] CPM_HIZ      = 3'h0;
	localparam logic [2:0] CPM_UP       = 3'h1;
	localparam logic [2:0] CPM_DOWN     = 3'h2;
	localparam logic [2:0] CPM_NORMAL   = 3'h3;
	localparam logic [7:0] UPDATE_VALUE = 8'h01;
	localparam logic [7:0] RST_MAIN     = 8'h01;
	localparam logic [7:0] RST_ABL      = 8'h00;
	localparam logic [7:0] RST_CAL      = 8'h00;
	localparam logic [7:0] RST_VDIV     = 8'h02;
	localparam logic [7:0] RST_SRC      = 8'h00;
	localparam logic [7:0] RST_ICP      = 8'h07;
	localparam int         MAIN_POL_BIT = 7;
	localparam int         SRC_BYP_BIT  = 0;
	localparam int         SRC_VCO_BIT  = 1;
	localparam int         CAL_BIT      = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Charge pump current, base step and top value in microamps.
	localparam logic [12:0] ICP_STEP_UA = 13'd600;
	localparam logic [12:0] ICP_MAX_UA  = 13'd4800;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers.
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [7:0] main;
		logic [7:0] abl;
		logic [7:0] cal;
		logic [7:0] vdiv;
		logic [7:0] src;
		logic [7:0] icp;
	} regs_t;

	typedef struct packed {
		logic        pwrdn;
		logic        src_vco;
		logic        div_bypass;
		logic [2:0]  vco_div_ratio;
		logic        neg_pol;
		logic [1:0]  abl_sel;
		logic [12:0] cp_ua;
		logic        cp_hiz;
		logic        cp_up;
		logic        cp_dn;
		logic        cal_start;
	} path_cfg_t;

	typedef struct packed {
		regs_t      pend;
		regs_t      act;
		logic       upd;
		logic [7:0] rdata;
		logic [2:0] ref_sync;
		logic [2:0] fb_sync;
		path_cfg_t  path;
	} ctl_state_t;

	typedef struct packed {
		logic       up;
		logic       dn;
		logic [2:0] cnt;
	} pfd_state_t;

endpackage

// ===== design/pfd_core.sv
`timescale 1ns/1ps
module pfd_core (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ref_edge,
	input  wire logic       fb_edge,
	input  wire logic [1:0] abl_sel,
	output logic            pump_up,
	output logic            pump_dn
);
	import pll_cfg_pkg::*;

	pfd_state_t st_r;
	pfd_state_t st_nxt;

	// Antibacklash width in clock cycles for each setting.
	function automatic logic [2:0] abl_cycles(input logic [1:0] sel);
		abl_cycles = {1'b0, sel} + 3'h1;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reference edge sets up, feedback edge sets down; both set clears after the pulse.
	always_comb begin
		st_nxt = st_r;
		if (st_r.up && st_r.dn) begin
			if (st_r.cnt >= abl_cycles(abl_sel) - 3'h1) begin
				st_nxt.up  = 1'b0;
				st_nxt.dn  = 1'b0;
				st_nxt.cnt = 3'h0;
			end else begin
				st_nxt.cnt = st_r.cnt + 3'h1;
			end
		end else begin
			if (ref_edge) begin
				st_nxt.up = 1'b1;
			end
			if (fb_edge) begin
				st_nxt.dn = 1'b1;
			end
			st_nxt.cnt = 3'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pump_up = st_r.up;
	assign pump_dn = st_r.dn;

	a_abl_release: assert property (@(posedge clk) disable iff (rst)
		(st_r.up && st_r.dn) |-> ##[1:4] !(st_r.up && st_r.dn))
		else $error("Antibacklash pulse did not end in time.");

endmodule

// ===== design/pll_clock_path_config.sv
`timescale 1ns/1ps
// Overview of operation
// - Power field 01 powers down, 00 runs.
// - Source bit 0 bypasses the VCO divider.
// - Source bit 1 picks internal VCO, else external.
// - Divider field selects ratio 2 to 6.
// - Calibration bit then update starts calibration.
// - Settings apply only after update value written.
// - Polarity bit: 0 positive, 1 negative.
// - Polarity applies only with an external VCO.
// - Two-bit field sets antibacklash pulse width.
// - Pump mode: high impedance, normal, up, down.
// - Pump current in eight equal steps.
// - Detector compares reference and feedback dividers.
// - Reset: PLL off, divide four, divider used, external.
module pll_clock_path_config (
	input  wire logic                             SYS_CLK,
	input  wire logic                             RST,
	input  wire pll_cfg_pkg::bus_req_t            BUS,
	input  wire logic                             REF_DIV_IN,
	input  wire logic                             FB_DIV_IN,
	output logic [pll_cfg_pkg::DATA_W-1:0]        RDATA,
	output pll_cfg_pkg::path_cfg_t                PATH
);
	import pll_cfg_pkg::*;

	ctl_state_t st_r;
	ctl_state_t st_nxt;
	logic       pfd_up;
	logic       pfd_dn;
	logic       ref_edge;
	logic       fb_edge;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.
	function automatic logic [2:0] vdiv_ratio(input logic [2:0] code);
		case (code)
			3'h0:    vdiv_ratio = 3'h2;
			3'h1:    vdiv_ratio = 3'h3;
			3'h2:    vdiv_ratio = 3'h4;
			3'h3:    vdiv_ratio = 3'h5;
			default: vdiv_ratio = 3'h6;
		endcase
	endfunction

	function automatic logic [12:0] cp_current(input logic [2:0] code);
		cp_current = (13'(code) + 13'h1) * ICP_STEP_UA;
	endfunction

	function automatic regs_t reg_write(input regs_t r, input bus_req_t b);
		reg_write = r;
		case (b.addr)
			ADDR_PLL_MAIN:   reg_write.main = b.wdata;
			ADDR_ABL_CTRL:   reg_write.abl  = b.wdata;
			ADDR_VCO_CAL:    reg_write.cal  = b.wdata;
			ADDR_VDIV_SEL:   reg_write.vdiv = b.wdata;
			ADDR_DIST_SRC:   reg_write.src  = b.wdata;
			ADDR_CP_CURRENT: reg_write.icp  = b.wdata;
			default:         reg_write = r;
		endcase
	endfunction

	localparam regs_t REGS_RESET = '{main: RST_MAIN, abl: RST_ABL, cal: RST_CAL,
		vdiv: RST_VDIV, src: RST_SRC, icp: RST_ICP};

	assign ref_edge = st_r.ref_sync[1] && !st_r.ref_sync[2];
	assign fb_edge  = st_r.fb_sync[1] && !st_r.fb_sync[2];

	////////////////////////////////////////////////////////////////////////////////
	// Phase detector.
	pfd_core u_pfd (
		.clk      (SYS_CLK),
		.rst      (RST),
		.ref_edge (ref_edge),
		.fb_edge  (fb_edge),
		.abl_sel  (st_r.act.abl[1:0]),
		.pump_up  (pfd_up),
		.pump_dn  (pfd_dn)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		st_nxt = st_r;
		st_nxt.ref_sync = {st_r.ref_sync[1:0], REF_DIV_IN};
		st_nxt.fb_sync  = {st_r.fb_sync[1:0], FB_DIV_IN};

		// Written values land in the pending copy only.
		if (BUS.wr) begin
			st_nxt.pend = reg_write(st_r.pend, BUS);
		end

		// Transfer of pending settings; the strobe bit clears on the same edge.
		if (st_r.upd) begin
			st_nxt.act = st_r.pend;
			st_nxt.upd = 1'b0;
		end
		if (BUS.wr && BUS.addr == ADDR_UPDATE && BUS.wdata == UPDATE_VALUE) begin
			st_nxt.upd = 1'b1;
		end

		// Calibration starts on a new zero to one of the active bit.
		st_nxt.path.cal_start = st_r.upd && st_r.pend.cal[CAL_BIT]
			&& !st_r.act.cal[CAL_BIT];

		// Clock path controls from the active copy.
		st_nxt.path.pwrdn         = (st_r.act.main[1:0] != PWR_RUN);
		st_nxt.path.div_bypass    = st_r.act.src[SRC_BYP_BIT];
		st_nxt.path.src_vco       = st_r.act.src[SRC_VCO_BIT];
		st_nxt.path.vco_div_ratio = vdiv_ratio(st_r.act.vdiv[2:0]);
		st_nxt.path.neg_pol       = st_r.act.main[MAIN_POL_BIT]
			&& !st_r.act.src[SRC_VCO_BIT];
		st_nxt.path.abl_sel       = st_r.act.abl[1:0];
		st_nxt.path.cp_ua         = cp_current(st_r.act.icp[2:0]);

		// Charge pump drive.
		st_nxt.path.cp_hiz = 1'b1;
		st_nxt.path.cp_up  = 1'b0;
		st_nxt.path.cp_dn  = 1'b0;
		if (st_r.act.main[1:0] == PWR_RUN) begin
			case (st_r.act.main[6:4])
				CPM_UP: begin
					st_nxt.path.cp_hiz = 1'b0;
					st_nxt.path.cp_up  = 1'b1;
				end
				CPM_DOWN: begin
					st_nxt.path.cp_hiz = 1'b0;
					st_nxt.path.cp_dn  = 1'b1;
				end
				CPM_NORMAL: begin
					st_nxt.path.cp_hiz = 1'b0;
					st_nxt.path.cp_up  = st_nxt.path.neg_pol ? pfd_dn : pfd_up;
					st_nxt.path.cp_dn  = st_nxt.path.neg_pol ? pfd_up : pfd_dn;
				end
				default: begin
					st_nxt.path.cp_hiz = 1'b1;
				end
			endcase
		end

		// Register read, data in the following cycle.
		st_nxt.rdata = 8'h00;
		if (BUS.rd) begin
			case (BUS.addr)
				ADDR_PLL_MAIN:   st_nxt.rdata = st_r.pend.main;
				ADDR_ABL_CTRL:   st_nxt.rdata = st_r.pend.abl;
				ADDR_VCO_CAL:    st_nxt.rdata = st_r.pend.cal;
				ADDR_VDIV_SEL:   st_nxt.rdata = st_r.pend.vdiv;
				ADDR_DIST_SRC:   st_nxt.rdata = st_r.pend.src;
				ADDR_CP_CURRENT: st_nxt.rdata = st_r.pend.icp;
				ADDR_UPDATE:     st_nxt.rdata = {7'h00, st_r.upd};
				ADDR_STATUS:     st_nxt.rdata = {3'h0, st_r.path.pwrdn, st_r.path.cp_hiz,
					st_r.path.cp_dn, st_r.path.cp_up, st_r.act.cal[CAL_BIT]};
				default:         st_nxt.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			st_r            <= '0;
			st_r.pend       <= REGS_RESET;
			st_r.act        <= REGS_RESET;
			st_r.path.pwrdn <= 1'b1;
			st_r.path.vco_div_ratio <= vdiv_ratio(RST_VDIV[2:0]);
			st_r.path.cp_ua  <= ICP_MAX_UA;
			st_r.path.cp_hiz <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA = st_r.rdata;
	assign PATH  = st_r.path;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_update_apply: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r.upd |=> (st_r.act == $past(st_r.pend)))
		else $error("Pending settings were not transferred on update.");

	a_no_early_apply: assert property (@(posedge SYS_CLK) disable iff (RST)
		!st_r.upd |=> (st_r.act == $past(st_r.act)))
		else $error("Active settings changed without an update.");

	a_update_selfclr: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS.wr && BUS.addr == ADDR_UPDATE && BUS.wdata == UPDATE_VALUE) ##1
		!(BUS.wr && BUS.addr == ADDR_UPDATE) |=> !st_r.upd)
		else $error("Update bit did not clear after the transfer.");

	a_cal_start_edge: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r.path.cal_start |-> (st_r.act.cal[CAL_BIT] && !$past(st_r.act.cal[CAL_BIT])))
		else $error("Calibration started without a new zero to one.");

	a_pwr_gate_pump: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.main[1:0] == PWR_DOWN) |-> (st_r.path.pwrdn && st_r.path.cp_hiz
		&& !st_r.path.cp_up && !st_r.path.cp_dn))
		else $error("Charge pump active while powered down.");

	a_pol_fixed_vco: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r.path.src_vco |-> !st_r.path.neg_pol)
		else $error("Polarity inverted with internal VCO.");

	a_div_ratio_map: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.vdiv[2:0]) == 3'h2 |-> st_r.path.vco_div_ratio == 3'h4)
		else $error("Divider code two does not give divide by four.");

	a_cp_current_step: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r.path.cp_ua == (13'($past(st_r.act.icp[2:0])) + 13'h1) * ICP_STEP_UA)
		else $error("Charge pump current step is wrong.");

	a_pump_test_up: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.main[6:4] == CPM_UP && st_r.act.main[1:0] == PWR_RUN)
		|-> (st_r.path.cp_up && !st_r.path.cp_dn && !st_r.path.cp_hiz))
		else $error("Constant pump up mode not driven.");

	a_src_bypass: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r.path.div_bypass == $past(st_r.act.src[SRC_BYP_BIT])
		&& st_r.path.src_vco == $past(st_r.act.src[SRC_VCO_BIT]))
		else $error("Source or bypass selection does not follow active copy.");

	a_reset_default: assert property (@(posedge SYS_CLK)
		$past(RST) |-> (st_r.act.main[1:0] == PWR_DOWN && st_r.act.vdiv[2:0] == 3'h2
		&& st_r.act.src[1:0] == 2'h0))
		else $error("Reset defaults wrong.");

	a_read_pending: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS.rd && BUS.addr == ADDR_DIST_SRC) |=> st_r.rdata == $past(st_r.pend.src))
		else $error("Read does not return the pending copy.");

	a_main_write: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS.wr && BUS.addr == ADDR_PLL_MAIN) |=> st_r.pend.main == $past(BUS.wdata))
		else $error("Write did not land in the pending copy.");

	a_upd_set: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS.wr && BUS.addr == ADDR_UPDATE && BUS.wdata == UPDATE_VALUE) |=> st_r.upd)
		else $error("Update write did not set the strobe bit.");

	a_upd_refused: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS.wr && BUS.addr == ADDR_UPDATE && BUS.wdata != UPDATE_VALUE && !st_r.upd)
		|=> !st_r.upd)
		else $error("Update accepted with a wrong value.");

	a_upd_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
		(st_r.upd && !(BUS.wr && BUS.addr == ADDR_UPDATE && BUS.wdata == UPDATE_VALUE))
		|=> !st_r.upd)
		else $error("Update bit stayed set after the transfer.");

	a_update_read: assert property (@(posedge SYS_CLK) disable iff (RST)
		(BUS.rd && BUS.addr == ADDR_UPDATE) |=> st_r.rdata == {7'h00, $past(st_r.upd)})
		else $error("Update register read back wrong.");

	a_cal_one_cycle: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r.path.cal_start |=> !st_r.path.cal_start)
		else $error("Calibration start longer than one cycle.");

	a_cal_needs_upd: assert property (@(posedge SYS_CLK) disable iff (RST)
		!st_r.upd |=> !st_r.path.cal_start)
		else $error("Calibration started without an update.");

	a_run_power: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.main[1:0] == PWR_RUN) |-> !st_r.path.pwrdn)
		else $error("PLL stays down with the run code.");

	a_div_ratio_top: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.vdiv[2:0]) >= 3'h4 |-> st_r.path.vco_div_ratio == 3'h6)
		else $error("Upper divider codes do not give divide by six.");

	a_abl_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
		st_r.path.abl_sel == $past(st_r.act.abl[1:0]))
		else $error("Antibacklash setting does not follow active copy.");

	a_pol_ext: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.main[MAIN_POL_BIT] && !st_r.act.src[SRC_VCO_BIT]) |-> st_r.path.neg_pol)
		else $error("Negative polarity not applied with external source.");

	a_pump_test_dn: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.main[6:4] == CPM_DOWN && st_r.act.main[1:0] == PWR_RUN)
		|-> (st_r.path.cp_dn && !st_r.path.cp_up && !st_r.path.cp_hiz))
		else $error("Constant pump down mode not driven.");

	a_pump_hiz_mode: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.main[6:4] == CPM_HIZ)
		|-> (st_r.path.cp_hiz && !st_r.path.cp_up && !st_r.path.cp_dn))
		else $error("Pump not at high impedance in holdover mode.");

	a_pump_normal: assert property (@(posedge SYS_CLK) disable iff (RST)
		$past(st_r.act.main[6:4] == CPM_NORMAL && st_r.act.main[1:0] == PWR_RUN)
		|-> (st_r.path.cp_up == (st_r.path.neg_pol ? $past(pfd_dn) : $past(pfd_up))))
		else $error("Pump does not follow the detector in normal mode.");

	c_cal_start: cover property (@(posedge SYS_CLK) disable iff (RST) st_r.path.cal_start);
	c_pump_dn: cover property (@(posedge SYS_CLK) disable iff (RST) st_r.path.cp_dn);
	c_neg_pol: cover property (@(posedge SYS_CLK) disable iff (RST) st_r.path.neg_pol);
	c_update: cover property (@(posedge SYS_CLK) disable iff (RST) st_r.upd ##1 !st_r.upd);
	c_normal_pump: cover property (@(posedge SYS_CLK) disable iff (RST)
		st_r.path.cp_up ##[1:20] st_r.path.cp_dn);

endmodule

// ===== verification/pll_clock_path_config_tb.sv
`timescale 1ns/1ps
module pll_clock_path_config_tb_top;
	import pll_cfg_pkg::*;

	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              ref_in = 1'b0;
	logic              fb_in = 1'b0;
	bus_req_t          bus = '0;
	logic [DATA_W-1:0] rdata;
	path_cfg_t         path;
	int                fails = 0;
	int                num_checks = 0;
	logic [7:0]        d;
	int                n;

	always #2.5 clk = ~clk;

	pll_clock_path_config dut (
		.SYS_CLK    (clk),
		.RST        (rst),
		.BUS        (bus),
		.REF_DIV_IN (ref_in),
		.FB_DIV_IN  (fb_in),
		.RDATA      (rdata),
		.PATH       (path)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus cycles and the compare task.
	task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		#1;
		v = rdata;
	endtask

	task automatic upd();
		wr(ADDR_UPDATE, UPDATE_VALUE);
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic set_upd(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		wr(a, v);
		upd();
	endtask

	task automatic cal_run(output int cnt);
		cnt = 0;
		wr(ADDR_UPDATE, UPDATE_VALUE);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1;
			if (path.cal_start === 1'b1) cnt++;
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset();
		#1;
		chk("pwrdn", 1, path.pwrdn);
		chk("ratio", 4, path.vco_div_ratio);
		chk("bypass", 0, path.div_bypass);
		chk("src_vco", 0, path.src_vco);
		chk("cp_ua", ICP_MAX_UA, path.cp_ua);
		rd(ADDR_PLL_MAIN, d);
		chk("main", RST_MAIN, d);
		rd(ADDR_VDIV_SEL, d);
		chk("vdiv", RST_VDIV, d);
		@(posedge clk);
		#1;
		chk("rdata idle", 0, rdata);
		rd(ADDR_STATUS, d);
		chk("status", 8'h18, d);
		rd(10'h3FF, d);
		chk("unmapped", 0, d);
	endtask

	task automatic t_update();
		wr(ADDR_DIST_SRC, 8'h02);
		repeat (4) @(posedge clk);
		#1;
		chk("held", 0, path.src_vco);
		rd(ADDR_DIST_SRC, d);
		chk("pend", 8'h02, d);
		wr(ADDR_UPDATE, 8'h02);
		repeat (4) @(posedge clk);
		#1;
		chk("bad upd", 0, path.src_vco);
		upd();
		chk("src_vco", 1, path.src_vco);
		chk("bypass", 0, path.div_bypass);
		rd(ADDR_UPDATE, d);
		chk("upd clr", 0, d);
		set_upd(ADDR_DIST_SRC, 8'h01);
		chk("bypass", 1, path.div_bypass);
		chk("src ext", 0, path.src_vco);
	endtask

	task automatic t_fields();
		for (int c = 0; c < 8; c++) begin
			set_upd(ADDR_VDIV_SEL, 8'(c));
			chk("ratio", (c > 4) ? 6 : c + 2, path.vco_div_ratio);
			set_upd(ADDR_CP_CURRENT, 8'(c));
			chk("cp_ua", 13'((c + 1) * 600), path.cp_ua);
		end
		for (int c = 0; c < 4; c++) begin
			set_upd(ADDR_ABL_CTRL, 8'(c));
			chk("abl", c, path.abl_sel);
		end
		set_upd(ADDR_PLL_MAIN, 8'h30);
		chk("run", 0, path.pwrdn);
		set_upd(ADDR_PLL_MAIN, 8'h31);
		chk("down", 1, path.pwrdn);
		set_upd(ADDR_PLL_MAIN, 8'h10);
		chk("pump up", 1, path.cp_up);
		chk("not dn", 0, path.cp_dn);
		set_upd(ADDR_PLL_MAIN, 8'h20);
		chk("pump dn", 1, path.cp_dn);
		set_upd(ADDR_PLL_MAIN, 8'h00);
		chk("hiz", 1, path.cp_hiz);
		set_upd(ADDR_PLL_MAIN, 8'hB0);
		chk("neg ext", 1, path.neg_pol);
		set_upd(ADDR_DIST_SRC, 8'h02);
		chk("pol vco", 0, path.neg_pol);
		set_upd(ADDR_DIST_SRC, 8'h00);
	endtask

	task automatic t_cal();
		wr(ADDR_VCO_CAL, 8'h01);
		cal_run(n);
		chk("cal 1st", 1, n);
		cal_run(n);
		chk("cal again", 0, n);
		wr(ADDR_VCO_CAL, 8'h00);
		cal_run(n);
		chk("cal clear", 0, n);
		wr(ADDR_VCO_CAL, 8'h01);
		cal_run(n);
		chk("cal 2nd", 1, n);
	endtask

	task automatic t_pfd();
		set_upd(ADDR_PLL_MAIN, 8'h30);
		@(posedge clk);
		ref_in <= 1'b1;
		n = 0;
		for (int i = 0; i < 10 && n == 0; i++) begin
			@(posedge clk);
			#1;
			if (path.cp_up === 1'b1) n = 1;
		end
		chk("ref up", 1, n);
		@(posedge clk);
		fb_in <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		chk("up idle", 0, path.cp_up);
		chk("dn idle", 0, path.cp_dn);
		@(posedge clk);
		ref_in <= 1'b0;
		fb_in <= 1'b0;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_update();
		t_fields();
		t_cal();
		t_pfd();
		stop_test();
	end
endmodule
